// File: serial_rx_defines.vh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Word-addressed Wishbone map, byte address = 4 * index
// Notes: Included by both design files
`ifndef SERIAL_RX_DEFINES_VH
`define SERIAL_RX_DEFINES_VH
// Register indices, byte address is four times the index
`define IDX_BUF 10'h208
`define IDX_CTRL 10'h209
`define IDX_MODE 10'h20a
`define IDX_IRQ_STAT 10'h20b
`define IDX_IRQ_MASK 10'h20c
// Mode register fields
`define MODE_TX9 7
`define MODE_HANDSHAKE_GATE_ENABLE 6
`define MODE_RXE 5
`define MODE_WU 4
`define MODE_SM_HI 3
`define MODE_SM_LO 2
`define MODE_SC_HI 1
`define MODE_SC_LO 0
`define MODE_RESET 8'h00
// Control register fields
`define CTRL_RX9 7
`define CTRL_EVEN 6
`define CTRL_PE 5
`define CTRL_OVR 4
`define CTRL_PAR 3
`define CTRL_FRM 2
`define CTRL_SCLKS 1
`define CTRL_IOC 0
`define CTRL_RESET 8'h00
// Interrupt status and mask fields
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_ERR 2
// Transfer mode encodings
`define SM_SHIFT 2'b00
`define SM_UART7 2'b01
`define SM_UART8 2'b10
`define SM_UART9 2'b11
// Base clock source encodings
`define SC_TIMER 2'b00
`define SC_BAUD 2'b01
`define SC_SYS 2'b10
`define SC_PIN 2'b11
// Base clock pulses per bit and the three sample points
`define TICKS_PER_BIT 16
`define SAMPLE_A 7
`define SAMPLE_B 8
`define SAMPLE_C 9
`define SHIFT_BITS 8
`endif

// File: bit_majority_sampler.v
// Purpose: Counts base clock pulses per bit, votes three samples
// Assumes: tick_i is a one-cycle pulse of the base clock
// Notes: centre_o pulses one cycle after the last sample pulse
`include "serial_rx_defines.vh"
module bit_majority_sampler #(
  parameter TICKS = `TICKS_PER_BIT
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire restart_i,
  input wire line_i,
  output reg centre_o,
  output reg bit_o
);
  reg [4:0] cnt_r; // Pulse number within the bit, 1 based
  reg [4:0] cnt_nxt; // Pulse number counted by this tick
  reg samp_a_r; // First sample
  reg samp_b_r; // Second sample

  // Restart counts the current tick as pulse one of a new bit
  always @*
  begin
    if (restart_i)
      cnt_nxt = 5'h01;
    else if (cnt_r == TICKS[4:0])
      cnt_nxt = 5'h01;
    else
      cnt_nxt = cnt_r + 5'h01;
  end

  // Take samples on pulses 7 and 8, vote on pulse 9
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 5'h00;
      samp_a_r <= 1'b1;
      samp_b_r <= 1'b1;
      centre_o <= 1'b0;
      bit_o <= 1'b1;
    end
    else
    begin
      centre_o <= 1'b0;
      if (tick_i)
      begin
        cnt_r <= cnt_nxt;
        if (cnt_nxt == `SAMPLE_A)
          samp_a_r <= line_i;
        if (cnt_nxt == `SAMPLE_B)
          samp_b_r <= line_i;
        if (cnt_nxt == `SAMPLE_C)
        begin
          centre_o <= 1'b1;
          bit_o <= (samp_a_r & samp_b_r) | (samp_a_r & line_i) |
            (samp_b_r & line_i);
        end
      end
    end
  end
endmodule // bit_majority_sampler

// File: serial_rx_errors_and_mode_control.v
// Purpose: One serial channel: receive errors, interrupt timing, mode
// Assumes: Pins synchronous to clk_i; classic Wishbone slave
// Notes: Shift mode and 7/8/9-bit UART; baud divider lives outside
//
// Behaviour
// - Overrun when new frame meets unread buffer
// - Parity of moved data checked against bit
// - Stop bit voted; majority zero gives framing
// - Receive interrupt point depends on format
// - Framing at stop centre, parity at parity
// - Overrun flagged at receive interrupt point
// - Transmit interrupt just before stop bit
// - Shift mode transmit interrupt after rising edge
// - Falling mode transmit interrupt after falling edge
// - Shift receive interrupt at buffer transfer
// - Mode field selects shift, 7, 8, 9 bit
// - Clock select picks UART base clock
// - Handshake enable gates UART transmit with clear-to-send
// - Wake-up enable bit; mode resets to zero
// - Nine-bit wake-up interrupts only on ninth one
// - Sixteen pulses per bit, majority of 7-9
// - Control register read clears all error flags
//
// Chosen here: the Wishbone interface to the registers.
`include "serial_rx_defines.vh"
module serial_rx_errors_and_mode_control #(
  parameter ADR_W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire [ADR_W-1:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire serial_in_pin_i,
  input wire cts_n_i,
  input wire shift_clock_pin_i,
  input wire timer_a0_match_i,
  input wire baud_tick_i,
  output reg serial_out_pin_o,
  output reg shift_clock_pin_o,
  output reg shift_clock_oe_o,
  output reg rx_interrupt_o,
  output reg tx_interrupt_o,
  output reg irq_o
);
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS = 2'd2;
  localparam RX_STOP = 2'd3;
  localparam TX_IDLE = 2'd0;
  localparam TX_START = 2'd1;
  localparam TX_BITS = 2'd2;
  localparam TX_STOP = 2'd3;

  // Parity bit for 7 or 8 data bits; even makes the total even
  function par_bit;
    input [7:0] d;
    input eight;
    input even;
    begin
      par_bit = (^(eight ? d : {1'b0, d[6:0]})) ^ ~even;
    end
  endfunction

  reg [7:0] mode_r; // serial_mode_control
  reg [7:0] ctrl_r; // Flags, parity setup, shift clock setup
  reg [2:0] irq_stat_r; // Sticky interrupt events
  reg [2:0] irq_mask_r; // Interrupt enables
  reg [7:0] rx_holding_buffer_r; // Data seen by software
  reg rx_valid_r; // Holding buffer not yet read
  reg [7:0] tx_buf_r; // Byte written for sending
  reg tx_full_r; // Transmit buffer holds a byte
  reg sclk_prev_r; // Shift clock pin, previous cycle
  reg [1:0] rx_st_r;
  reg [3:0] rx_cnt_r; // Received bit index
  reg [8:0] rx_sh_r; // Receive shift stage
  reg [8:0] rx_word; // Shift stage with the current bit
  reg [1:0] tx_st_r;
  reg [3:0] tx_cnt_r; // Bits left to send
  reg [3:0] tx_div_r; // Base pulses within a transmit bit
  reg [8:0] tx_sh_r; // Transmit shift stage
  reg uart_out_r; // UART line level
  reg [3:0] io_cnt_r; // Shift mode edge count
  reg [7:0] io_tx_r; // Shift mode transmit stage
  reg [7:0] io_rx_r; // Shift mode receive stage
  reg io_busy_r; // Device driven shift clock running
  reg sclk_out_r; // Device driven shift clock level
  reg rx_evt; // Receive interrupt event
  reg tx_evt; // Transmit interrupt event
  reg [2:0] err_set; // Overrun, parity, framing set pulses
  reg xfer; // Move a character to the holding buffer
  reg [8:0] xfer_word;
  reg base_tick; // One pulse of the UART base clock

  wire [1:0] sm = {mode_r[`MODE_SM_HI], mode_r[`MODE_SM_LO]};
  wire [1:0] sc = {mode_r[`MODE_SC_HI], mode_r[`MODE_SC_LO]};
  wire receive_enable_bit = mode_r[`MODE_RXE];
  wire pe = ctrl_r[`CTRL_PE] & (sm != `SM_UART9); // No parity in 9-bit
  wire uart = (sm != `SM_SHIFT);
  wire [3:0] data_n = (sm == `SM_UART7) ? 4'd7 : 4'd8;
  wire [3:0] last_idx = data_n - ((sm == `SM_UART9) | pe ? 4'd0 : 4'd1);
  // Formats whose interrupt falls at the last bit, not the stop bit
  wire early = (sm == `SM_UART9) | ((sm == `SM_UART8) & pe);
  wire hit = cyc_i & stb_i & ~ack_o;
  wire [ADR_W-3:0] idx = adr_i[ADR_W-1:2];
  wire rd_ctrl = hit & ~we_i & (idx == `IDX_CTRL);
  wire rd_buf = hit & ~we_i & (idx == `IDX_BUF);
  wire wr_lo = hit & we_i & sel_i[0];
  wire smp_centre;
  wire smp_bit;
  wire sclk_rise = shift_clock_pin_i & ~sclk_prev_r;
  wire sclk_fall = ~shift_clock_pin_i & sclk_prev_r;
  wire out_rise = baud_tick_i & io_busy_r & ~sclk_out_r;
  // Active shift edge: own clock rises, or pin edge chosen by sclks
  wire io_edge = ctrl_r[`CTRL_IOC] ?
    (ctrl_r[`CTRL_SCLKS] ? sclk_fall : sclk_rise) : out_rise;
  // Clear-to-send is low active; gating only when enabled
  wire tx_go = ~mode_r[`MODE_HANDSHAKE_GATE_ENABLE] | ~cts_n_i;
  // Next own shift clock level; the pin follows it so that the last rise
  // and the shift interrupts leave on the same edge
  wire sclk_nxt = uart ? 1'b1 :
    ((io_busy_r & baud_tick_i) ? ~sclk_out_r : sclk_out_r);

  // UART base clock source
  always @*
  begin
    case (sc)
      `SC_TIMER: base_tick = timer_a0_match_i;
      `SC_BAUD: base_tick = baud_tick_i;
      `SC_SYS: base_tick = 1'b1;
      default: base_tick = sclk_rise;
    endcase
  end

  // Shift stage as it stands with the bit sampled now
  always @*
  begin
    rx_word = rx_sh_r;
    rx_word[rx_cnt_r] = smp_bit;
  end

  bit_majority_sampler #(
    .TICKS(`TICKS_PER_BIT)
  ) u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(base_tick),
    .restart_i(uart & (rx_st_r == RX_IDLE) & receive_enable_bit & ~serial_in_pin_i),
    .line_i(serial_in_pin_i),
    .centre_o(smp_centre),
    .bit_o(smp_bit)
  );

  // Receive events of both modes, all gated by receive enable
  always @*
  begin
    xfer = 1'b0;
    xfer_word = rx_word;
    err_set = 3'b000;
    if (!uart)
    begin
      // Character complete after the eighth shift edge
      xfer = receive_enable_bit & io_edge & (io_cnt_r == `SHIFT_BITS - 1);
      xfer_word = {1'b0, serial_in_pin_i, io_rx_r[7:1]};
    end
    else if (receive_enable_bit & smp_centre)
    begin
      if (rx_st_r == RX_BITS && rx_cnt_r == last_idx)
      begin
        xfer = early;
        if (pe && smp_bit != par_bit(rx_word[7:0], sm == `SM_UART8,
          ctrl_r[`CTRL_EVEN]))
          err_set[1] = 1'b1;
      end
      if (rx_st_r == RX_STOP)
      begin
        xfer = ~early;
        xfer_word = rx_sh_r;
        err_set[0] = ~smp_bit;
      end
    end
    err_set[2] = xfer & rx_valid_r;
    // Nine-bit wake-up withholds the interrupt for frames whose ninth bit is zero; the data still loads
    rx_evt = xfer & ~rx_valid_r & ~(sm == `SM_UART9 &
      mode_r[`MODE_WU] & ~xfer_word[8]);
  end

  // Wishbone slave: answer one cycle after the request, any address
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= hit;
      if (hit & ~we_i)
      begin
        case (idx)
          `IDX_BUF: dat_o <= {24'h00_0000, rx_holding_buffer_r};
          `IDX_CTRL: dat_o <= {24'h00_0000, ctrl_r};
          `IDX_MODE: dat_o <= {24'h00_0000, mode_r};
          `IDX_IRQ_STAT: dat_o <= {29'h0000_0000, irq_stat_r};
          `IDX_IRQ_MASK: dat_o <= {29'h0000_0000, irq_mask_r};
          default: dat_o <= 32'h0000_0000; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Software registers and flags; hardware set wins over any clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= `MODE_RESET;
      ctrl_r <= `CTRL_RESET;
      irq_stat_r <= 3'b000;
      irq_mask_r <= 3'b000;
      tx_buf_r <= 8'h00;
      tx_full_r <= 1'b0;
      rx_holding_buffer_r <= 8'h00;
      rx_valid_r <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr_lo && idx == `IDX_MODE)
        mode_r <= dat_i[7:0];
      if (wr_lo && idx == `IDX_CTRL)
      begin
        ctrl_r[`CTRL_EVEN] <= dat_i[`CTRL_EVEN];
        ctrl_r[`CTRL_PE] <= dat_i[`CTRL_PE];
        ctrl_r[`CTRL_SCLKS] <= dat_i[`CTRL_SCLKS];
        ctrl_r[`CTRL_IOC] <= dat_i[`CTRL_IOC];
      end
      // Reading the control register clears every error flag
      ctrl_r[`CTRL_OVR] <= err_set[2] | (ctrl_r[`CTRL_OVR] & ~rd_ctrl);
      ctrl_r[`CTRL_PAR] <= err_set[1] | (ctrl_r[`CTRL_PAR] & ~rd_ctrl);
      ctrl_r[`CTRL_FRM] <= err_set[0] | (ctrl_r[`CTRL_FRM] & ~rd_ctrl);
      if (wr_lo && idx == `IDX_IRQ_MASK)
        irq_mask_r <= dat_i[2:0];
      irq_stat_r[`IRQ_RX] <= rx_evt | (irq_stat_r[`IRQ_RX] &
        ~(wr_lo && idx == `IDX_IRQ_STAT && dat_i[`IRQ_RX]));
      irq_stat_r[`IRQ_TX] <= tx_evt | (irq_stat_r[`IRQ_TX] &
        ~(wr_lo && idx == `IDX_IRQ_STAT && dat_i[`IRQ_TX]));
      irq_stat_r[`IRQ_ERR] <= (|err_set) | (irq_stat_r[`IRQ_ERR] &
        ~(wr_lo && idx == `IDX_IRQ_STAT && dat_i[`IRQ_ERR]));
      irq_o <= |(irq_stat_r & irq_mask_r);
      // An overrun keeps the old buffer and ninth bit
      if (xfer & ~rx_valid_r)
      begin
        rx_holding_buffer_r <= xfer_word[7:0];
        ctrl_r[`CTRL_RX9] <= xfer_word[8];
      end
      rx_valid_r <= (xfer & ~rx_valid_r) | (rx_valid_r & ~rd_buf);
      // A write in the load cycle stays pending rather than lost
      if (wr_lo && idx == `IDX_BUF)
      begin
        tx_buf_r <= dat_i[7:0];
        tx_full_r <= 1'b1;
      end
      else if ((uart && tx_st_r == TX_IDLE && tx_div_r == 4'hf &&
        base_tick && tx_go) || (!uart && !io_busy_r &&
        !ctrl_r[`CTRL_IOC]) || (!uart && ctrl_r[`CTRL_IOC] &&
        io_cnt_r == 4'h0 && io_edge))
        tx_full_r <= 1'b0;
    end
  end

  // UART receive sequence: start, data and extra bits, stop
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end
    else if (!uart || !receive_enable_bit)
      rx_st_r <= RX_IDLE;
    else
    begin
      case (rx_st_r)
        RX_IDLE:
          if (base_tick && !serial_in_pin_i)
            rx_st_r <= RX_START;
        RX_START:
          if (smp_centre)
          begin
            // A start bit voted high was only a glitch
            rx_st_r <= smp_bit ? RX_IDLE : RX_BITS;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 9'h000;
          end
        RX_BITS:
          if (smp_centre)
          begin
            rx_sh_r <= rx_word;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == last_idx)
              rx_st_r <= RX_STOP;
          end
        default:
          if (smp_centre)
            rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // UART transmit: one bit per sixteen base pulses
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_st_r <= TX_IDLE;
      tx_cnt_r <= 4'h0;
      tx_div_r <= 4'h0;
      tx_sh_r <= 9'h1ff;
      uart_out_r <= 1'b1;
    end
    else if (!uart)
    begin
      tx_st_r <= TX_IDLE;
      uart_out_r <= 1'b1;
    end
    else if (base_tick)
    begin
      tx_div_r <= tx_div_r + 4'h1;
      if (tx_div_r == 4'hf)
      begin
        case (tx_st_r)
          TX_IDLE:
            if (tx_full_r && tx_go)
            begin
              tx_st_r <= TX_START;
              uart_out_r <= 1'b0;
              tx_cnt_r <= last_idx + 4'h1;
              tx_sh_r <= {mode_r[`MODE_TX9], tx_buf_r};
              if (pe && sm == `SM_UART7)
                tx_sh_r[7] <= par_bit(tx_buf_r, 1'b0, ctrl_r[`CTRL_EVEN]);
              if (pe && sm == `SM_UART8)
                tx_sh_r[8] <= par_bit(tx_buf_r, 1'b1, ctrl_r[`CTRL_EVEN]);
            end
          TX_START, TX_BITS:
            if (tx_cnt_r == 4'h0)
            begin
              tx_st_r <= TX_STOP;
              uart_out_r <= 1'b1;
            end
            else
            begin
              tx_st_r <= TX_BITS;
              uart_out_r <= tx_sh_r[0];
              tx_sh_r <= {1'b1, tx_sh_r[8:1]};
              tx_cnt_r <= tx_cnt_r - 4'h1;
            end
          default:
            tx_st_r <= TX_IDLE;
        endcase
      end
    end
  end

  // Shift mode: sample, shift and count on the active edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      io_cnt_r <= 4'h0;
      io_tx_r <= 8'hff;
      io_rx_r <= 8'h00;
      io_busy_r <= 1'b0;
      sclk_out_r <= 1'b1;
      sclk_prev_r <= 1'b1;
    end
    else
    begin
      sclk_prev_r <= shift_clock_pin_i;
      if (uart)
      begin
        io_cnt_r <= 4'h0;
        io_busy_r <= 1'b0;
        sclk_out_r <= 1'b1;
      end
      else
      begin
        // Own clock starts only once a byte waits to be sent
        if (!io_busy_r && tx_full_r && !ctrl_r[`CTRL_IOC])
        begin
          io_busy_r <= 1'b1;
          io_tx_r <= tx_buf_r;
        end
        else if (io_busy_r && baud_tick_i)
          sclk_out_r <= ~sclk_out_r;
        if (ctrl_r[`CTRL_IOC] && io_cnt_r == 4'h0 && io_edge)
          io_tx_r <= tx_full_r ? tx_buf_r : 8'hff;
        if (io_edge)
        begin
          io_rx_r <= {serial_in_pin_i, io_rx_r[7:1]};
          if (!(ctrl_r[`CTRL_IOC] && io_cnt_r == 4'h0))
            io_tx_r <= {1'b1, io_tx_r[7:1]};
          io_cnt_r <= (io_cnt_r == `SHIFT_BITS - 1) ? 4'h0 :
            io_cnt_r + 4'h1;
          if (io_cnt_r == `SHIFT_BITS - 1)
            io_busy_r <= 1'b0;
        end
      end
    end
  end

  // Transmit interrupt: entering the stop bit, or last shift edge
  always @*
  begin
    if (uart)
      tx_evt = base_tick && tx_div_r == 4'hf && tx_cnt_r == 4'h0 &&
        (tx_st_r == TX_START || tx_st_r == TX_BITS);
    else
      tx_evt = io_edge && io_cnt_r == `SHIFT_BITS - 1;
  end

  // Registered pins and interrupt pulses
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_out_pin_o <= 1'b1;
      shift_clock_pin_o <= 1'b1;
      shift_clock_oe_o <= 1'b0;
      rx_interrupt_o <= 1'b0;
      tx_interrupt_o <= 1'b0;
    end
    else
    begin
      serial_out_pin_o <= uart ? uart_out_r : io_tx_r[0];
      shift_clock_pin_o <= sclk_nxt;
      shift_clock_oe_o <= ~uart & ~ctrl_r[`CTRL_IOC];
      rx_interrupt_o <= rx_evt;
      tx_interrupt_o <= tx_evt;
    end
  end
endmodule // serial_rx_errors_and_mode_control

// File: serial_channel_checker_assertions.sv
// Purpose: Port-level timing checks for the serial channel block
// Assumes: One clock, synchronous active-high reset
// Notes: Ioc=1 shift mode is also covered by the stop-bit check
module serial_channel_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic serial_out_pin_o,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_oe_o,
  input wire logic rx_interrupt_o,
  input wire logic tx_interrupt_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_reset_idle: assert property ($fell(rst_i) |-> !ack_o && !irq_o
    && serial_out_pin_o && shift_clock_pin_o && !shift_clock_oe_o
    && !rx_interrupt_o && !tx_interrupt_o)
    else $error("outputs not idle after reset");
  // A fresh request is answered in the next cycle
  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_rx_pulse: assert property (rx_interrupt_o |=> !rx_interrupt_o)
    else $error("receive interrupt not a pulse");
  a_tx_pulse: assert property (tx_interrupt_o |=> !tx_interrupt_o)
    else $error("transmit interrupt not a pulse");
  // The stop bit follows the transmit interrupt in UART formats
  a_tx_stop: assert property (tx_interrupt_o && !shift_clock_oe_o
    |-> ##1 serial_out_pin_o [*8])
    else $error("line not at stop level after transmit interrupt");
  // Own shift clock: interrupt lands just after a rising edge
  a_shift_tx: assert property (tx_interrupt_o && shift_clock_oe_o
    |-> shift_clock_pin_o && !$past(shift_clock_pin_o, 2))
    else $error("shift transmit interrupt not after rising edge");
endmodule // serial_channel_checker
bind serial_rx_errors_and_mode_control serial_channel_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .serial_out_pin_o(serial_out_pin_o),
  .shift_clock_pin_o(shift_clock_pin_o),
  .shift_clock_oe_o(shift_clock_oe_o), .rx_interrupt_o(rx_interrupt_o),
  .tx_interrupt_o(tx_interrupt_o), .irq_o(irq_o));

// File: serial_peer_model.sv
// Purpose: Remote UART sender and clear-to-send source
// Assumes: Bit time given in system clocks by the caller
// Notes: Line idles high, as a pulled-up serial line would
module serial_peer_model (
  input wire logic clk_i,
  output logic line_o,
  output logic cts_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    line_o = 1'b1;
    cts_n_o = 1'b1;
  end
  // Start bit, nb bits LSB first, then a stop bit of chosen level
  task automatic send(input logic [8:0] d, input int nb, input int tb,
    input logic stop);
    for (int i = -1; i <= nb; i++)
    begin
      line_o <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
      repeat (tb) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule // serial_peer_model

// File: test_serial_rx_errors_and_mode_control.sv
// Purpose: Self-checking bench for the serial channel block
// Assumes: Base clock is the system clock or a 1-in-3 pulse train
// Notes: Random bytes from a fixed seed; a queue holds expected data
`include "serial_rx_defines.vh"
module test_serial_rx_errors_and_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sp;
  logic timer_a0_match_i = 0, baud_tick_i = 0, shift_clock_pin_i = 0;
  logic [11:0] adr_i = 12'h000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h0;
  logic [7:0] rd, b;
  logic [8:0] d;
  logic [1:0] sm;
  logic pe;
  wire [31:0] dat_o;
  wire ack_o, line, cts_n, serial_out_pin_o, shift_clock_pin_o;
  wire shift_clock_oe_o, rx_interrupt_o, tx_interrupt_o, irq_o;
  int n_mismatch = 0, checks = 0, seed = 39166, div = 0, tpb = 1;
  int t, e, n, nb;
  logic [7:0] q[$]; // Bytes the receiver should hand over
  serial_rx_errors_and_mode_control uut (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .serial_in_pin_i(line), .cts_n_i(cts_n),
    .shift_clock_pin_i(shift_clock_pin_i),
    .timer_a0_match_i(timer_a0_match_i), .baud_tick_i(baud_tick_i),
    .serial_out_pin_o(serial_out_pin_o),
    .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_oe_o(shift_clock_oe_o), .rx_interrupt_o(rx_interrupt_o),
    .tx_interrupt_o(tx_interrupt_o), .irq_o(irq_o));
  serial_peer_model peer (.clk_i(clk_i), .line_o(line), .cts_n_o(cts_n));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // Slow base sources pulse every third clock
  always @(posedge clk_i)
  begin
    div <= (div == 2) ? 0 : div + 1;
    timer_a0_match_i <= (div == 0);
    baud_tick_i <= (div == 0);
    shift_clock_pin_i <= (div == 0);
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [9:0] idx,
    input logic [7:0] v);
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h1;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h00_0000, v};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Send a frame and note the cycle of the receive interrupt
  task automatic frame(input logic [8:0] fd, input int fb, input logic st);
    t = -1;
    fork
      peer.send(fd, fb, 16 * tpb, st);
      for (int c = 0; c < 16 * tpb * (fb + 3); c++)
      begin
        @(posedge clk_i);
        if (rx_interrupt_o === 1'b1 && t < 0) t = c;
      end
    join
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #200_000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `IDX_MODE, 8'h00);
    check("mode reset", rd, 8'h00);
    wb(1'b0, 10'h210, 8'h00);
    check("unmapped", rd, 8'h00);
    b = $random(seed);
    wb(1'b1, `IDX_MODE, b);
    wb(1'b0, `IDX_MODE, 8'h00);
    check("mode rw", rd, b);
    wb(1'b1, `IDX_IRQ_MASK, 8'h07);
    // Every UART format, parity on and off in 7 and 8 bit, 9 bit without, system clock base
    for (int k = 0; k < 5; k++)
    begin
      sm = (k < 2) ? 2'b01 : (k < 4) ? 2'b10 : 2'b11;
      pe = (k < 4) && k[0];
      nb = 7 + (sm != 2'b01) + pe + (sm == 2'b11);
      b = $random(seed);
      if (sm == 2'b01) b[7] = pe ? ~^b[6:0] : 1'b0;
      d = {(sm == 2'b11) | (pe & ~^b), b};
      q.push_back(b);
      wb(1'b1, `IDX_CTRL, {2'b00, pe, 5'h00});
      wb(1'b1, `IDX_MODE, {3'b001, 1'b0, sm, 2'b10});
      frame(d, nb, 1'b1);
      e = ((nb == 9) ? 9 : nb + 1) * 16 + 8;
      check("rx point", t >= e - 2 && t <= e + 6, 1'b1);
      check("irq set", irq_o, 1'b1);
      wb(1'b1, `IDX_IRQ_STAT, 8'h07);
      check("irq clear", irq_o, 1'b0);
      wb(1'b0, `IDX_BUF, 8'h00);
      check("rx data", rd, q.pop_front());
      wb(1'b0, `IDX_CTRL, 8'h00);
      check("no error", rd & 8'h1c, 8'h00);
    end
    // Parity error, flag clear on read; 8-bit with odd parity
    wb(1'b1, `IDX_CTRL, 8'h20);
    wb(1'b1, `IDX_MODE, 8'h2a);
    b = $random(seed);
    frame({^b, b}, 9, 1'b1);
    wb(1'b0, `IDX_BUF, 8'h00);
    wb(1'b0, `IDX_CTRL, 8'h00);
    check("parity flag", rd & 8'h1c, 8'h08);
    wb(1'b0, `IDX_CTRL, 8'h00);
    check("flags read clear", rd & 8'h1c, 8'h00);
    // Overrun: second frame meets an unread buffer
    for (int k = 0; k < 2; k++)
    begin
      d[7:0] = $random(seed);
      if (k == 0) b = d[7:0];
      frame({~^d[7:0], d[7:0]}, 9, 1'b1);
    end
    check("overrun no irq", t, -1);
    wb(1'b1, `IDX_MODE, 8'h0a);
    wb(1'b0, `IDX_BUF, 8'h00);
    check("overrun keeps", rd, b);
    wb(1'b0, `IDX_CTRL, 8'h00);
    check("overrun flag", rd & 8'h1c, 8'h10);
    frame({^b, b}, 9, 1'b1);
    check("rx off irq", t, -1);
    wb(1'b0, `IDX_CTRL, 8'h00);
    check("rx off flags", rd & 8'h1c, 8'h00);
    wb(1'b1, `IDX_MODE, 8'h2a);
    frame({~^b, b}, 9, 1'b0);
    wb(1'b1, `IDX_MODE, 8'h0a);
    wb(1'b0, `IDX_CTRL, 8'h00);
    check("framing flag", rd & 8'h1c, 8'h04);
    wb(1'b0, `IDX_BUF, 8'h00);
    // Nine-bit wake-up: only a set ninth bit interrupts
    wb(1'b1, `IDX_CTRL, 8'h00);
    wb(1'b1, `IDX_MODE, 8'h3e);
    for (int k = 0; k < 2; k++)
    begin
      d = {k[0], 8'h00};
      d[7:0] = $random(seed);
      frame(d, 9, 1'b1);
      check("wake irq", t >= 0, k[0]);
      wb(1'b0, `IDX_BUF, 8'h00);
      check("wake data", rd, d[7:0]);
    end
    // Other base clock sources, with interrupts masked
    wb(1'b1, `IDX_IRQ_MASK, 8'h00);
    wb(1'b1, `IDX_IRQ_STAT, 8'h07);
    tpb = 3;
    for (int k = 0; k < 4; k = k + 1 + (k == 1))
    begin
      b = $random(seed);
      wb(1'b1, `IDX_MODE, {6'b0010_10, k[1:0]});
      frame({1'b0, b}, 8, 1'b1);
      wb(1'b0, `IDX_BUF, 8'h00);
      check("base clock data", rd, b);
    end
    tpb = 1;
    check("irq masked", irq_o, 1'b0);
    wb(1'b1, `IDX_IRQ_MASK, 8'h07);
    check("irq unmasked", irq_o, 1'b1);
    wb(1'b1, `IDX_IRQ_STAT, 8'h07);
    // Transmit with handshake on, then off with clear-to-send high
    for (int k = 0; k < 2; k++)
    begin
      peer.cts_n_o <= 1'b1;
      b = $random(seed);
      wb(1'b1, `IDX_MODE, k ? 8'h0a : 8'h4a);
      wb(1'b1, `IDX_BUF, b);
      for (n = 0; serial_out_pin_o === 1'b1 && n < 300; n++)
        @(posedge clk_i);
      check("tx held", n == 300, !k[0]);
      peer.cts_n_o <= 1'b0;
      for (n = 0; serial_out_pin_o === 1'b1 && n < 300; n++)
        @(posedge clk_i);
      t = -1;
      for (int c = 0; c < 160; c++)
      begin
        @(posedge clk_i);
        if (c % 16 == 8 && c > 16 && c < 144) rd = {serial_out_pin_o, rd[7:1]};
        if (tx_interrupt_o === 1'b1 && t < 0) t = c;
      end
      check("tx data", rd, b);
      check("tx point", t >= 138 && t <= 148, 1'b1);
    end
    // Shift mode with own clock; idle input line gives all ones
    wb(1'b1, `IDX_MODE, 8'h20);
    wb(1'b1, `IDX_BUF, $random(seed));
    n = 0;
    e = -1;
    t = -1;
    sp = 1'b1;
    for (int c = 0; c < 200; c++)
    begin
      @(posedge clk_i);
      if (shift_clock_pin_o === 1'b1 && sp === 1'b0) n++;
      sp = shift_clock_pin_o;
      if (tx_interrupt_o === 1'b1) t = n;
      if (rx_interrupt_o === 1'b1) e = n;
    end
    check("shift tx edges", t, 8);
    check("shift rx edges", e, 8);
    wb(1'b0, `IDX_BUF, 8'h00);
    check("shift rx data", rd, 8'hff);
    conclude();
  end
endmodule // test_serial_rx_errors_and_mode_control
